// [bench/ssps_spi_master.sv]
`timescale 1ns/10ps
`default_nettype none
module ssps_spi_master
   import ssps_pkg::*;
#(
   parameter int HALF = 8
)
(
   input wire logic clk_i,
   input wire logic sdo_i,
   output var ssps_pins_in_t pins_o
);
   // clock idles low and moves only while shift runs, whether or not select is low
   initial pins_o = '{sck: 1'b0, sdi: 1'b0, ss_n: 1'b1};

   task automatic sel(input logic v);
      @(posedge clk_i);
      pins_o.ss_n <= v;
      repeat (HALF) @(posedge clk_i);
   endtask

   // mode 0,0: idle low, data set before the rising edge, read at it
   task automatic shift(input logic [7:0] tx, input int n, output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 0; i < n; i++)
      begin
         pins_o.sdi <= tx[7 - i];
         repeat (HALF) @(posedge clk_i);
         pins_o.sck <= 1'b1;
         rx = {rx[6:0], sdo_i};
         repeat (HALF) @(posedge clk_i);
         pins_o.sck <= 1'b0;
      end
      // a released line must not keep its last level
      pins_o.sdi <= ~pins_o.sdi;
   endtask
endmodule // ssps_spi_master
`default_nettype wire

// [bench/ssps_top_tb.sv]
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) \
begin \
   n_tests++; \
   if ((g) !== (e)) \
   begin \
      error_cnt++; \
      $display("MISMATCH %s exp %0h got %0h", nm, e, g); \
   end \
end
module ssps_top_tb
   import ssps_pkg::*;
;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [4:0] adr = 5'h00;
   logic [31:0] wdat = 32'h0;
   logic we = 1'b0, cyc = 1'b0, stb = 1'b0, psel = 1'b0, sleep = 1'b0;
   logic [1:0] dir = 2'h3;
   logic [31:0] rdat;
   logic ack;
   logic [1:0] irq;
   ssps_pins_in_t p1;
   ssps_pins_in_t p2 = '{sck: 1'b0, sdi: 1'b1, ss_n: 1'b1};
   ssps_pins_out_t o1, o2;
   logic [7:0] q, rx, cap = 8'h00;
   logic sck_d = 1'b0, s;
   logic tick = 1'b0;
   logic [3:0] lanes = 4'hF;
   int error_cnt = 0, n_tests = 0, cyc_cnt = 0, n;

   always #4 clk_i = ~clk_i;

   ssps_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_we_i(we), .wb_sel_i(lanes), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_ack_o(ack), .port_sel_i(psel), .sleep_i(sleep), .timer_tick_i(tick),
      .pins1_i(p1), .pins2_i(p2), .sdo_dir_out_i(dir), .pins1_o(o1), .pins2_o(o2),
      .port_irq_flag_o(irq));

   ssps_spi_master i_master (.clk_i(clk_i), .sdo_i(o1.sdo_o), .pins_o(p1));

   // bits seen on the master's data line at each rising serial clock
   always @(posedge clk_i)
   begin
      sck_d <= o2.sck_o;
      tick <= (cyc_cnt[1:0] == 2'b11);
      if (o2.sck_o && !sck_d)
         cap <= {cap[6:0], o2.sdo_o};
      cyc_cnt++;
      if (cyc_cnt == 10000)
      begin
         error_cnt++;
         final_report;
      end
   end

   task automatic wb(input logic p, input logic [4:0] a, input logic w, input logic [7:0] d);
      @(posedge clk_i);
      psel <= p;
      adr <= a;
      we <= w;
      wdat <= {24'h0, d};
      cyc <= 1'b1;
      stb <= 1'b1;
      do @(posedge clk_i); while (ack !== 1'b1);
      q = rdat[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   task automatic final_report;
      $display("checks %0d errors %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   initial
   begin
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      // last address is unmapped
      for (int a = 0; a < 6; a++)
      begin
         wb(1'b0, 5'(a * 4), 1'b0, 8'h00);
         `CHK("reset", 8'h00, q)
      end
      wb(1'b0, SSPS_STAT_OFS, 1'b1, 8'hFF);
      wb(1'b0, SSPS_STAT_OFS, 1'b0, 8'h00);
      `CHK("stat_rw", 8'hC0, q)
      wb(1'b0, SSPS_CON2_OFS, 1'b1, 8'h5A);
      wb(1'b0, SSPS_CON2_OFS, 1'b0, 8'h00);
      `CHK("con2", 8'h5A, q)
      wb(1'b0, SSPS_ADDR_OFS, 1'b1, 8'h7F);
      wb(1'b0, SSPS_ADDR_OFS, 1'b0, 8'h00);
      `CHK("addr", 8'h7F, q)
      // a write without lane zero must leave the register alone
      lanes <= 4'hE;
      wb(1'b0, SSPS_CON2_OFS, 1'b1, 8'h00);
      lanes <= 4'hF;
      wb(1'b0, SSPS_CON2_OFS, 1'b0, 8'h00);
      `CHK("lane0_off", 8'h5A, q)
      wb(1'b0, SSPS_STAT_OFS, 1'b1, 8'h40);
      wb(1'b0, SSPS_CON1_OFS, 1'b1, {4'h2, SSPS_M_SLV_SS});
      wb(1'b0, SSPS_BUF_OFS, 1'b1, 8'hA5);
      i_master.sel(1'b0);
      `CHK("oe_sel", 1'b1, o1.sdo_oe)
      i_master.shift(8'h3C, 8, rx);
      `CHK("slave_tx", 8'hA5, rx)
      i_master.sel(1'b1);
      `CHK("irq_slv", 1'b1, irq[0])
      `CHK("oe_desel", 1'b0, o1.sdo_oe)
      wb(1'b0, SSPS_STAT_OFS, 1'b0, 8'h00);
      `CHK("stat_bf", 8'h41, q)
      `CHK("irq_clr", 1'b0, irq[0])
      wb(1'b0, SSPS_BUF_OFS, 1'b0, 8'h00);
      `CHK("slave_rx", 8'h3C, q)
      // a half byte, then deselect: the next byte must start afresh
      i_master.sel(1'b0);
      i_master.shift(8'hFF, 4, rx);
      i_master.sel(1'b1);
      `CHK("irq_abort", 1'b0, irq[0])
      i_master.sel(1'b0);
      i_master.shift(8'h81, 8, rx);
      i_master.sel(1'b1);
      wb(1'b0, SSPS_BUF_OFS, 1'b0, 8'h00);
      `CHK("rx_after", 8'h81, q)
      @(posedge clk_i);
      dir <= 2'b10;
      i_master.sel(1'b0);
      `CHK("oe_dir", 1'b0, o1.sdo_oe)
      i_master.sel(1'b1);
      dir <= 2'b11;
      wb(1'b0, SSPS_CON1_OFS, 1'b1, {4'h2, SSPS_M_SLV});
      wb(1'b0, SSPS_STAT_OFS, 1'b0, 8'h00);
      i_master.shift(8'h0F, 8, rx);
      repeat (8) @(posedge clk_i);
      `CHK("irq_nosel", 1'b1, irq[0])
      wb(1'b1, SSPS_STAT_OFS, 1'b1, 8'h40);
      wb(1'b1, SSPS_CON1_OFS, 1'b1, {4'h2, SSPS_M_DIV4});
      `CHK("sck_idle", 1'b0, o2.sck_o)
      wb(1'b1, SSPS_BUF_OFS, 1'b1, 8'h96);
      wb(1'b1, SSPS_BUF_OFS, 1'b1, 8'h00);
      wb(1'b1, SSPS_CON1_OFS, 1'b0, 8'h00);
      `CHK("write_collision", 8'hA0, q)
      sleep <= 1'b1;
      repeat (2) @(posedge clk_i);
      s = o2.sck_o;
      repeat (20) @(posedge clk_i);
      `CHK("sleep_sck", s, o2.sck_o)
      sleep <= 1'b0;
      n = 0;
      while (irq[1] !== 1'b1 && n < 200)
      begin
         @(posedge clk_i);
         n++;
      end
      `CHK("irq_mst", 1'b1, irq[1])
      `CHK("mst_tx", 8'h96, cap)
      `CHK("port1_kept", 1'b1, irq[0])
      wb(1'b1, SSPS_BUF_OFS, 1'b0, 8'h00);
      `CHK("mst_rx", 8'hFF, q)
      wb(1'b1, SSPS_CON1_OFS, 1'b1, {4'h2, SSPS_M_TMR});
      wb(1'b1, SSPS_STAT_OFS, 1'b0, 8'h00);
      wb(1'b1, SSPS_BUF_OFS, 1'b1, 8'h5A);
      n = 0;
      while (irq[1] !== 1'b1 && n < 400)
      begin
         @(posedge clk_i);
         n++;
      end
      `CHK("irq_tmr", 1'b1, irq[1])
      `CHK("tmr_tx", 8'h5A, cap)
      final_report;
   end
endmodule // ssps_top_tb
`default_nettype wire

// [hdl/ssps_pkg.sv]
package ssps_pkg;
   // register word offsets (byte addresses, one 32-bit word each)
   localparam logic [4:0] SSPS_BUF_OFS = 5'h00;
   localparam logic [4:0] SSPS_CON1_OFS = 5'h04;
   localparam logic [4:0] SSPS_STAT_OFS = 5'h08;
   localparam logic [4:0] SSPS_CON2_OFS = 5'h0C;
   localparam logic [4:0] SSPS_ADDR_OFS = 5'h10;
   localparam logic [1:0] SSPS_PORT1 = 2'h0;
   localparam logic [1:0] SSPS_PORT2 = 2'h1;
   // control one fields
   localparam int SSPS_WRITE_COLLISION_BIT = 7;
   localparam int SSPS_OVF_BIT = 6;
   localparam int SSPS_EN_BIT = 5;
   localparam int SSPS_CKP_BIT = 4;
   // status fields
   localparam int SSPS_SMP_BIT = 7;
   localparam int SSPS_CKE_BIT = 6;
   localparam int SSPS_BF_BIT = 0;
   localparam logic [7:0] SSPS_STAT_WMASK = 8'hC0;
   localparam logic [7:0] SSPS_REG_RST = 8'h00;
   // mode codes
   localparam logic [3:0] SSPS_M_DIV4 = 4'h0;
   localparam logic [3:0] SSPS_M_DIV16 = 4'h1;
   localparam logic [3:0] SSPS_M_DIV64 = 4'h2;
   localparam logic [3:0] SSPS_M_TMR = 4'h3;
   localparam logic [3:0] SSPS_M_SLV_SS = 4'h4;
   localparam logic [3:0] SSPS_M_SLV = 4'h5;
   // half-period reload counts of the master clock: half period in core cycles minus one
   localparam logic [5:0] SSPS_HALF_DIV4 = 6'h01;
   localparam logic [5:0] SSPS_HALF_DIV16 = 6'h07;
   localparam logic [5:0] SSPS_HALF_DIV64 = 6'h1F;
   localparam logic [2:0] SSPS_LAST_BIT = 3'h7;

   typedef struct packed {
      logic sck;
      logic sdi;
      logic ss_n;
   } ssps_pins_in_t;

   typedef struct packed {
      logic sck_o;
      logic sck_oe;
      logic sdo_o;
      logic sdo_oe;
   } ssps_pins_out_t;

   typedef struct packed {
      logic [7:0] buffer;
      logic [7:0] shifter;
      logic [7:0] con1;
      logic [7:0] stat_cfg;
      logic [7:0] con2;
      logic [7:0] addr;
      logic bf;
      logic irq;
      logic busy;
      logic [2:0] bitcnt;
      logic [5:0] div;
      logic sck_out;
      logic sdo;
      logic rx_bit;
      logic [2:0] sck_sync;
      logic [2:0] ss_sync;
      logic [2:0] sdi_sync;
      logic sck_prev;
   } ssps_port_t;
endpackage

// [hdl/ssps_top.sv]
// Function
// R01: select pin only acts in mode 0100
// R02: select low: shift and drive output
// R03: select high: output floats at once
// R04: select high or disable clears bit counter
// R05: software uses 0100 when edge bit set
// R06: output enable off means no driving
// R07: sleep freezes a master transfer in place
// R08: idle modes keep the peripheral clock
// R09: master completion raises the port interrupt
// R10: slave clocked by serial clock; flag after eight
// R11: reset disables port, aborts transfer
// R12: SPI modes map onto polarity and edge
// R13: sample phase bit picks input sample time
// R14: two ports run independently at own rates
// R15: shared timer changes both rates equally
// R16: I2C roles supported by register set
// R17: software sets I2C pins as inputs
// R18: status low six read-only, top two writable
// R19: control two bits 5:1 mode dependent names
// R20: address register doubles as reload value; the code only stores it, and the divider reloads fixed counts
// R21: received byte moves to buffer, sets flag
// R22: transmit write loads buffer and shifter
// R23: write while shifting dropped, sets collision
// R24: shift MSB first, eight bits a byte
// R25: mode codes select master rate or slave
// R26: polarity bit sets clock idle level
// R27: edge bit selects output change edge
// R28: pins synchronised before status updates
`timescale 1ns/10ps
`default_nettype none
module ssps_top
   import ssps_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [4:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   output logic wb_ack_o,
   input wire logic port_sel_i,
   input wire logic sleep_i,
   input wire logic timer_tick_i,
   input wire ssps_pins_in_t pins1_i,
   input wire ssps_pins_in_t pins2_i,
   input wire logic [1:0] sdo_dir_out_i,
   output ssps_pins_out_t pins1_o,
   output ssps_pins_out_t pins2_o,
   output logic [1:0] port_irq_flag_o
);
   typedef struct packed {
      ssps_port_t [1:0] p;
      logic timer_half;
      logic ack;
      logic [31:0] rdata;
   } ssps_state_t;

   ssps_state_t st;
   ssps_state_t next_st;

   function automatic logic [5:0] ssps_half(input logic [3:0] mode);
      case (mode)
         SSPS_M_DIV4: ssps_half = SSPS_HALF_DIV4;
         SSPS_M_DIV16: ssps_half = SSPS_HALF_DIV16;
         default: ssps_half = SSPS_HALF_DIV64;
      endcase
   endfunction

   function automatic logic ssps_is_slave(input logic [3:0] mode);
      ssps_is_slave = (mode == SSPS_M_SLV_SS) || (mode == SSPS_M_SLV);
   endfunction

   ssps_pins_in_t pin_in [2];
   assign pin_in[0] = pins1_i;
   assign pin_in[1] = pins2_i;

   logic req;
   logic [1:0] hit_port;
   logic hit_ok;
   assign req = wb_cyc_i && wb_stb_i && !st.ack;
   assign hit_port = {1'b0, port_sel_i};
   assign hit_ok = (wb_adr_i[1:0] == 2'b00) && (wb_adr_i <= SSPS_ADDR_OFS);

   always_comb
   begin
      logic [3:0] mode;
      logic ena;
      logic active_ss;
      logic sck_s;
      logic sck_e;
      logic lead;
      logic trail;
      logic shift_out;
      logic sample;
      logic done;
      logic tick;
      logic wr_lane;
      mode = 4'h0;
      ena = 1'b0;
      active_ss = 1'b0;
      sck_s = 1'b0;
      sck_e = 1'b0;
      lead = 1'b0;
      trail = 1'b0;
      shift_out = 1'b0;
      sample = 1'b0;
      done = 1'b0;
      tick = 1'b0;
      wr_lane = wb_sel_i[0];
      next_st = st;
      next_st.ack = req;
      if (timer_tick_i)
      begin
         next_st.timer_half = !st.timer_half;
      end
      for (int i = 0; i < 2; i++)
      begin
         mode = st.p[i].con1[3:0];
         ena = st.p[i].con1[SSPS_EN_BIT];
         // three-stage synchronisers, edges judged on stages two and three
         next_st.p[i].sck_sync = {st.p[i].sck_sync[1:0], pin_in[i].sck}; // see R28
         next_st.p[i].ss_sync = {st.p[i].ss_sync[1:0], pin_in[i].ss_n};
         next_st.p[i].sdi_sync = {st.p[i].sdi_sync[1:0], pin_in[i].sdi};
         if (st.p[i].sck_sync[2] == st.p[i].sck_sync[1])
         begin
            next_st.p[i].sck_prev = st.p[i].sck_sync[2];
         end
         active_ss = (mode == SSPS_M_SLV_SS) && st.p[i].ss_sync[2]; // see R01
         if (!ssps_is_slave(mode))
         begin
            // master: divider enable, frozen while sleeping
            tick = 1'b0;
            if (st.p[i].busy && !sleep_i) // see R07
            begin
               if (mode == SSPS_M_TMR)
               begin
                  tick = timer_tick_i && st.timer_half; // see R15
               end
               else if (st.p[i].div == 6'h00)
               begin
                  tick = 1'b1;
               end
               next_st.p[i].div = (st.p[i].div == 6'h00) ? ssps_half(mode) : // see R14
                                  st.p[i].div - 6'h01;
            end
            if (tick)
            begin
               next_st.p[i].sck_out = !st.p[i].sck_out;
               lead = (st.p[i].sck_out == st.p[i].con1[SSPS_CKP_BIT]);
               trail = !lead;
            end
         end
         else
         begin
            // slave: shifting follows external clock only
            sck_s = st.p[i].sck_sync[2];
            sck_e = (sck_s == st.p[i].sck_sync[1]) && (sck_s != st.p[i].sck_prev);
            if (sck_e && !active_ss) // see R02 R10
            begin
               lead = (sck_s != st.p[i].con1[SSPS_CKP_BIT]);
               trail = !lead;
            end
         end
         // edge bit chooses the output edge, sample on the other
         shift_out = st.p[i].stat_cfg[SSPS_CKE_BIT] ? trail : lead; // see R27 R12
         sample = st.p[i].stat_cfg[SSPS_CKE_BIT] ? lead : trail;
         if (sample)
         begin
            next_st.p[i].rx_bit = st.p[i].sdi_sync[2];
            // end-sample captures at the output edge, so take it one half later
            if (!st.p[i].stat_cfg[SSPS_SMP_BIT]) // see R13
            begin
               next_st.p[i].shifter = {st.p[i].shifter[6:0], st.p[i].sdi_sync[2]}; // see R24
            end
         end
         if (shift_out)
         begin
            if (st.p[i].stat_cfg[SSPS_SMP_BIT])
            begin
               next_st.p[i].shifter = {st.p[i].shifter[6:0], st.p[i].rx_bit};
            end
            next_st.p[i].sdo = st.p[i].shifter[7];
         end
         // a master counts on the return to idle so its clock always ends at rest;
         // a slave counts from its first edge, since it never sees a start command
         if ((ssps_is_slave(mode) ? (st.p[i].stat_cfg[SSPS_SMP_BIT] ? shift_out : sample) :
              trail) && (st.p[i].busy || ssps_is_slave(mode)))
         begin
            next_st.p[i].bitcnt = st.p[i].bitcnt + 3'h1;
            done = (st.p[i].bitcnt == SSPS_LAST_BIT);
         end
         else
         begin
            done = 1'b0;
         end
         if (sample && ssps_is_slave(mode))
         begin
            next_st.p[i].busy = 1'b1;
         end
         if (done)
         begin
            next_st.p[i].buffer = next_st.p[i].shifter; // see R21
            next_st.p[i].busy = ssps_is_slave(mode);
            next_st.p[i].bitcnt = 3'h0;
            next_st.p[i].irq = 1'b1; // see R09 R10
            if (st.p[i].bf)
            begin
               next_st.p[i].con1[SSPS_OVF_BIT] = 1'b1;
            end
            next_st.p[i].bf = 1'b1;
         end
         if (ssps_is_slave(mode) && st.p[i].bitcnt == 3'h0 && !done && !sample)
         begin
            next_st.p[i].busy = 1'b0;
         end
         if (!ena || active_ss) // see R04
         begin
            next_st.p[i].bitcnt = 3'h0;
            next_st.p[i].busy = 1'b0;
            next_st.p[i].div = 6'h00;
            next_st.p[i].sck_out = st.p[i].con1[SSPS_CKP_BIT]; // see R26
         end
         // register access to the selected port
         if (req && hit_ok && hit_port == i[1:0])
         begin
            if (wb_we_i && wr_lane)
            begin
               case (wb_adr_i)
                  SSPS_BUF_OFS:
                  begin
                     if (st.p[i].busy && ena)
                     begin
                        next_st.p[i].con1[SSPS_WRITE_COLLISION_BIT] = 1'b1; // see R23
                     end
                     else
                     begin
                        next_st.p[i].buffer = wb_dat_i[7:0]; // see R22
                        next_st.p[i].shifter = wb_dat_i[7:0];
                        next_st.p[i].sdo = wb_dat_i[7];
                        next_st.p[i].busy = ena && !ssps_is_slave(mode);
                        next_st.p[i].bitcnt = 3'h0;
                     end
                  end
                  SSPS_CON1_OFS:
                  begin
                     // hardware sets win over a software clear
                     next_st.p[i].con1 = wb_dat_i[7:0] | (next_st.p[i].con1 & 8'hC0 &
                                         ~st.p[i].con1);
                  end
                  SSPS_STAT_OFS: next_st.p[i].stat_cfg = wb_dat_i[7:0] & SSPS_STAT_WMASK; // see R18
                  SSPS_CON2_OFS: next_st.p[i].con2 = wb_dat_i[7:0]; // see R19
                  SSPS_ADDR_OFS: next_st.p[i].addr = wb_dat_i[7:0]; // see R20
                  default: next_st.p[i].con2 = st.p[i].con2;
               endcase
            end
            else if (!wb_we_i && wb_adr_i == SSPS_BUF_OFS && !done)
            begin
               next_st.p[i].bf = 1'b0;
            end
            if (!wb_we_i && wb_adr_i == SSPS_STAT_OFS)
            begin
               next_st.p[i].irq = done;
            end
         end
      end
      next_st.rdata = 32'h0000_0000;
      if (req && !wb_we_i && hit_ok)
      begin
         case (wb_adr_i)
            SSPS_BUF_OFS: next_st.rdata[7:0] = st.p[hit_port[0]].buffer;
            SSPS_CON1_OFS: next_st.rdata[7:0] = st.p[hit_port[0]].con1;
            SSPS_STAT_OFS: next_st.rdata[7:0] = st.p[hit_port[0]].stat_cfg |
                                                {7'h00, st.p[hit_port[0]].bf};
            SSPS_CON2_OFS: next_st.rdata[7:0] = st.p[hit_port[0]].con2;
            default: next_st.rdata[7:0] = st.p[hit_port[0]].addr;
         endcase
      end
      if (rst_i)
      begin
         next_st = '0; // see R11
      end
   end

   always_ff @(posedge clk_i)
   begin
      st <= next_st;
   end

   // output stage per port; data output floats when the select is high in mode 0100
   function automatic ssps_pins_out_t ssps_pins(input ssps_port_t p, input logic dir_out);
      logic [3:0] mode;
      mode = p.con1[3:0];
      ssps_pins.sck_o = p.sck_out;
      ssps_pins.sck_oe = p.con1[SSPS_EN_BIT] && !ssps_is_slave(mode);
      ssps_pins.sdo_o = p.sdo;
      ssps_pins.sdo_oe = p.con1[SSPS_EN_BIT] && dir_out && // see R06
                         !((mode == SSPS_M_SLV_SS) && p.ss_sync[2]); // see R03
   endfunction

   assign pins1_o = ssps_pins(st.p[0], sdo_dir_out_i[0]);
   assign pins2_o = ssps_pins(st.p[1], sdo_dir_out_i[1]);
   assign port_irq_flag_o = {st.p[1].irq, st.p[0].irq};
   assign wb_ack_o = st.ack;
   assign wb_dat_o = st.rdata;

   // the core clock keeps running in idle modes, so no gating is done here (see R08)

   property ack_one_a;
      @(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o;
   endproperty
   bus_ack_pulse_a: assert property (ack_one_a) else $error("ack held two cycles");

   ss_float_a: assert property (@(posedge clk_i) disable iff (rst_i) // see R03
      (st.p[0].con1[3:0] == SSPS_M_SLV_SS && st.p[0].ss_sync[2]) |-> !pins1_o.sdo_oe)
      else $error("data out driven with select high");

   ss_counter_a: assert property (@(posedge clk_i) disable iff (rst_i) // see R04
      (st.p[0].con1[3:0] == SSPS_M_SLV_SS && st.p[0].ss_sync[2]) |=> st.p[0].bitcnt == 3'h0)
      else $error("bit counter not cleared");

   disable_idle_a: assert property (@(posedge clk_i) disable iff (rst_i) // see R04
      !st.p[0].con1[SSPS_EN_BIT] |=> !st.p[0].busy) else $error("busy while disabled");

   sequence wr_buf_busy_s;
      req && wb_we_i && wb_sel_i[0] && !port_sel_i && wb_adr_i == SSPS_BUF_OFS &&
      st.p[0].busy && st.p[0].con1[SSPS_EN_BIT];
   endsequence
   write_collision_set_a: assert property (@(posedge clk_i) disable iff (rst_i) // see R23
      wr_buf_busy_s |=> st.p[0].con1[SSPS_WRITE_COLLISION_BIT]) else $error("collision not flagged");

   sleep_freeze_a: assert property (@(posedge clk_i) disable iff (rst_i) // see R07
      (sleep_i && !ssps_is_slave(st.p[0].con1[3:0]) && st.p[0].con1[SSPS_EN_BIT])
      |=> $stable(st.p[0].sck_out)) else $error("master clock moved in sleep");

   stat_ro_a: assert property (@(posedge clk_i) disable iff (rst_i) // see R18
      st.p[0].stat_cfg[5:0] == 6'h00) else $error("status low bits written");

   full_flag_a: assert property (@(posedge clk_i) disable iff (rst_i) // see R21
      $rose(st.p[0].irq) |-> st.p[0].bf) else $error("flag without full buffer");

   idle_level_a: assert property (@(posedge clk_i) disable iff (rst_i) // see R26
      (!st.p[0].busy && $past(!st.p[0].busy) && !st.p[0].con1[SSPS_EN_BIT])
      |-> pins1_o.sck_o == st.p[0].con1[SSPS_CKP_BIT]) else $error("clock not at idle level");
endmodule // ssps_top
`default_nettype wire
